// ===== rtl/serial_bootstrap_loader.sv
// bootstrap serial loader: break at start, first-character decision, download into ram
// assumes one ahb-lite master, rxPin from outside, tx pin pulled up externally
`timescale 1ns/1ns
`include "boot_loader_map.svh"
module serial_bootstrap_loader #(
    parameter int BIT_CYCLES = `BIT_CYCLES,
    parameter int RAM_DEPTH = `RAM_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial pins
    input wire logic rxPin,
    output logic txPinOut,
    output logic txPinOeN,
    // state handed to the core
    output logic programStart,
    output logic [15:0] jumpAddr,
    output logic [15:0] stackPtr,
    output logic serialRxEnable,
    output logic serialTxEnable,
    output logic serialPinOwn,
    output logic wireOrMode,
    output logic bootRomMapEnable,
    output logic resetDisable,
    output logic expandedMode,
    output logic privilegedAccess,
    output logic protectSuspend
);
    localparam int AW = $clog2(RAM_DEPTH);
    localparam int BW = $clog2(BIT_CYCLES + 1);
    localparam logic [5:0] IDLE_BITS = 6'(`IDLE_CHARS * `CHAR_BITS);
    localparam logic [5:0] START_BITS = 6'(`MIN_START_CHARS * `CHAR_BITS);

    boot_loader_pkg::state_t state_r;
    logic [7:0] ram [RAM_DEPTH];
    logic [6:0] ctrl_r;
    logic [15:0] jumpAddr_r, stackPtr_r;
    logic [31:0] timer_r, rdMux;
    logic [AW:0] loadCount_r;
    logic [BW-1:0] bitDiv_r;
    logic [5:0] idleBits_r, elapsedBits_r;
    logic bitTick, started_r, rxEn_r, txEn_r, pinOwn_r;
    logic rxValid, rxBreak, txLine, txBusy;
    logic [7:0] rxData, echoData_r;
    logic txSend_r, txBreak_r, echoPending_r;
    logic addrPhase, wrPend_r, hready_r, hresp_r;
    logic [11:0] wrAddr_r;
    logic [31:0] hrdata_r;

    serial_rx #(.BIT_CYCLES(BIT_CYCLES)) rxUnit (
        .clock(clock),
        .resetn(resetn),
        .rxPin(rxPin),
        .rxValid(rxValid),
        .rxData(rxData),
        .rxBreak(rxBreak)
    );

    serial_tx #(.BIT_CYCLES(BIT_CYCLES)) txUnit (
        .clock(clock),
        .resetn(resetn),
        .send(txSend_r),
        .sendBreak(txBreak_r),
        .data(echoData_r),
        .line(txLine),
        .busy(txBusy)
    );

    // open drain: only ever pull low, pull-up is external
    assign txPinOut = 1'b0;
    assign txPinOeN = txLine;
    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = hresp_r;
    assign programStart = started_r;
    assign jumpAddr = jumpAddr_r;
    assign stackPtr = stackPtr_r;
    assign serialRxEnable = rxEn_r;
    assign serialTxEnable = txEn_r;
    assign serialPinOwn = pinOwn_r;
    assign wireOrMode = ctrl_r[`CTRL_WIRE_OR];
    assign bootRomMapEnable = ctrl_r[`CTRL_BOOT_ROM];
    assign resetDisable = ctrl_r[`CTRL_RESET_DIS];
    assign expandedMode = ctrl_r[`CTRL_EXPANDED];
    assign privilegedAccess = ctrl_r[`CTRL_PRIV];
    assign protectSuspend = ctrl_r[`CTRL_PROT_OFF];

    // bit-time enable, free running from reset
    assign bitTick = bitDiv_r == BW'(BIT_CYCLES - 1);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bitDiv_r <= '0;
        end else begin
            bitDiv_r <= bitTick ? '0 : bitDiv_r + 1'b1;
        end
    end

    // elapsed bit times since reset, saturating
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            elapsedBits_r <= 6'h00;
        end else if (bitTick && elapsedBits_r < START_BITS) begin
            elapsedBits_r <= elapsedBits_r + 6'h01;
        end
    end

    // idle detector, only counts once the rate character moved us into loading
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            idleBits_r <= 6'h00;
        end else if (state_r != boot_loader_pkg::ST_LOAD || rxValid) begin
            idleBits_r <= 6'h00;
        end else if (bitTick && idleBits_r < IDLE_BITS) begin
            idleBits_r <= idleBits_r + 6'h01;
        end
    end

    // free-running timer, never cleared on the way to the program
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_r <= 32'h0000_0000;
        end else begin
            timer_r <= timer_r + 32'h0000_0001;
        end
    end

    // loader sequence
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= boot_loader_pkg::ST_BREAK;
            jumpAddr_r <= `ADDR_RAM_START;
            stackPtr_r <= 16'h0000;
            loadCount_r <= '0;
            started_r <= 1'b0;
            rxEn_r <= 1'b0;
            txEn_r <= 1'b0;
            pinOwn_r <= 1'b0;
            txBreak_r <= 1'b0;
        end else begin
            txBreak_r <= 1'b0;
            case (state_r)
                boot_loader_pkg::ST_BREAK: begin
                    rxEn_r <= 1'b1;
                    txEn_r <= 1'b1;
                    pinOwn_r <= 1'b1;
                    txBreak_r <= 1'b1;
                    state_r <= boot_loader_pkg::ST_FIRST;
                end
                boot_loader_pkg::ST_FIRST: begin
                    if (rxValid) begin
                        if (rxBreak || rxData == `CODE_EEPROM_JUMP) begin
                            jumpAddr_r <= `ADDR_EEPROM_START;
                            state_r <= boot_loader_pkg::ST_WAIT;
                        end else if (rxData == `CODE_RAM_JUMP) begin
                            jumpAddr_r <= `ADDR_RAM_START;
                            state_r <= boot_loader_pkg::ST_WAIT;
                        end else begin
                            // any other character is taken as the rate character
                            jumpAddr_r <= `ADDR_RAM_START;
                            state_r <= boot_loader_pkg::ST_LOAD;
                        end
                    end
                end
                boot_loader_pkg::ST_LOAD: begin
                    if (rxValid) begin
                        loadCount_r <= loadCount_r + 1'b1;
                        if ((ctrl_r[`CTRL_FIXED_LEN] && loadCount_r == (AW+1)'(`FIXED_LOAD_BYTES - 1))
                            || loadCount_r == (AW+1)'(RAM_DEPTH - 1)) begin
                            state_r <= boot_loader_pkg::ST_WAIT;
                        end
                    end else if (!ctrl_r[`CTRL_FIXED_LEN] && idleBits_r == IDLE_BITS) begin
                        state_r <= boot_loader_pkg::ST_WAIT;
                    end
                end
                boot_loader_pkg::ST_WAIT: begin
                    // let the last echo drain and the minimum start delay pass
                    if (elapsedBits_r == START_BITS && !txBusy && !echoPending_r && !txSend_r) begin
                        stackPtr_r <= `RAM_TOP;
                        started_r <= 1'b1;
                        state_r <= boot_loader_pkg::ST_RUN;
                    end
                end
                boot_loader_pkg::ST_RUN: begin
                    state_r <= boot_loader_pkg::ST_RUN;
                end
                default: begin
                    state_r <= boot_loader_pkg::ST_BREAK;
                end
            endcase
        end
    end

    // download store, ram needs no reset
    always_ff @(posedge clock) begin
        if (state_r == boot_loader_pkg::ST_LOAD && rxValid) begin
            ram[loadCount_r[AW-1:0]] <= rxData;
        end
    end

    // echo path: one holding byte; a new byte wins over the drain in the same cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            echoPending_r <= 1'b0;
            echoData_r <= 8'h00;
            txSend_r <= 1'b0;
        end else begin
            txSend_r <= 1'b0;
            if (echoPending_r && !txBusy && !txSend_r && !txBreak_r) begin
                txSend_r <= 1'b1;
                echoPending_r <= 1'b0;
            end
            if (state_r == boot_loader_pkg::ST_LOAD && rxValid) begin
                echoPending_r <= 1'b1;
                echoData_r <= rxData;
            end
        end
    end

    // mode control; loader forces open-drain, software may rewrite every bit
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `CTRL_RESET;
        end else begin
            if (wrPend_r && wrAddr_r == `REG_CTRL) begin
                ctrl_r <= hwdata[6:0];
            end
            if (state_r == boot_loader_pkg::ST_BREAK) begin
                ctrl_r[`CTRL_WIRE_OR] <= 1'b1;
            end
        end
    end

    // read decode
    always_comb begin
        rdMux = 32'h0000_0000;
        if (haddr[11]) begin
            rdMux = {24'h000000, ram[haddr[AW+1:2]]};
        end else if (haddr[11:0] == `REG_CTRL) begin
            rdMux = {25'h0000000, ctrl_r};
        end else if (haddr[11:0] == `REG_STATUS) begin
            rdMux = {25'h0000000, started_r, pinOwn_r, txEn_r, rxEn_r, state_r};
        end else if (haddr[11:0] == `REG_JUMP) begin
            rdMux = {16'h0000, jumpAddr_r};
        end else if (haddr[11:0] == `REG_STACK) begin
            rdMux = {16'h0000, stackPtr_r};
        end else if (haddr[11:0] == `REG_TIMER) begin
            rdMux = timer_r;
        end else if (haddr[11:0] == `REG_COUNT) begin
            rdMux = 32'(loadCount_r);
        end
    end

    // ahb-lite: zero wait, read data captured at the address phase, write at data phase
    assign addrPhase = hsel && htrans[1] && hready;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 12'h000;
            hrdata_r <= 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= haddr[11:0];
            hrdata_r <= (addrPhase && !hwrite) ? rdMux : 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence firstChar(logic [7:0] code);
        state_r == boot_loader_pkg::ST_FIRST && rxValid && !rxBreak && rxData == code;
    endsequence
    sequence startEdge;
        !started_r ##1 started_r;
    endsequence

    serialEnabled_a: assert property (started_r |-> rxEn_r && txEn_r) else $error("serial off at start");
    pinsOwned_a: assert property (state_r != boot_loader_pkg::ST_BREAK |-> pinOwn_r)
        else $error("pins not owned");
    wireOrStart_a: assert property (startEdge |-> ctrl_r[`CTRL_WIRE_OR] || $past(wrPend_r, 2))
        else $error("not open-drain");
    stackTop_a: assert property (startEdge |-> stackPtr_r == `RAM_TOP) else $error("stack pointer wrong");
    minDelay_a: assert property (startEdge |-> elapsedBits_r == START_BITS)
        else $error("program started too early");
    timerKeeps_a: assert property (startEdge |-> timer_r == $past(timer_r) + 32'h1)
        else $error("timer disturbed");
    ramJump_a: assert property (firstChar(`CODE_RAM_JUMP) |=> jumpAddr_r == `ADDR_RAM_START
        && state_r == boot_loader_pkg::ST_WAIT) else $error("ram jump missed");
    eepromJump_a: assert property (firstChar(`CODE_EEPROM_JUMP) |=> jumpAddr_r == `ADDR_EEPROM_START)
        else $error("eeprom jump missed");
    idleEnd_a: assert property (state_r == boot_loader_pkg::ST_LOAD && !rxValid && !ctrl_r[`CTRL_FIXED_LEN]
        && idleBits_r == IDLE_BITS |=> state_r == boot_loader_pkg::ST_WAIT) else $error("idle end missed");
    startBreak_a: assert property ($fell(state_r == boot_loader_pkg::ST_BREAK) |-> txBreak_r ##1 txBusy)
        else $error("no break at start");
endmodule : serial_bootstrap_loader

// ===== rtl/boot_loader_map.svh
// offsets, field positions, reset values, codes and timing counts of the bootstrap loader
// assumes inclusion by bare name from design files
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_JUMP 12'h008
`define REG_STACK 12'h00c
`define REG_TIMER 12'h010
`define REG_COUNT 12'h014
// control field positions
`define CTRL_BOOT_ROM 0
`define CTRL_RESET_DIS 1
`define CTRL_EXPANDED 2
`define CTRL_FIXED_LEN 3
`define CTRL_WIRE_OR 4
`define CTRL_PRIV 5
`define CTRL_PROT_OFF 6
`define CTRL_RESET 7'h63
// first-character codes
`define CODE_RAM_JUMP 8'h55
`define CODE_EEPROM_JUMP 8'h00
// addresses handed to the core
`define ADDR_RAM_START 16'h0000
`define ADDR_EEPROM_START 16'hb600
`define RAM_TOP 16'h01ff
`define RAM_DEPTH 512
// timing
`define CLK_PERIOD_NS 8
`define BIT_TIME_NS 128008
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define CHAR_BITS 10
`define IDLE_CHARS 4
`define MIN_START_CHARS 2
`define FIXED_LOAD_BYTES 256
`endif

// ===== rtl/boot_loader_pkg.sv
// types shared by the bootstrap loader files
// assumes nothing of its surroundings
package boot_loader_pkg;
    typedef enum logic [2:0] {
        ST_BREAK = 3'b000,
        ST_FIRST = 3'b001,
        ST_LOAD = 3'b010,
        ST_WAIT = 3'b011,
        ST_RUN = 3'b100
    } state_t;
endpackage : boot_loader_pkg

// ===== rtl/serial_rx.sv
// async serial receiver, 8n1, lsb first, mid-bit sampling
// assumes rxPin is asynchronous to clock
`timescale 1ns/1ns
module serial_rx #(
    parameter int BIT_CYCLES = 16001
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // line and result
    input wire logic rxPin,
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxBreak
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    logic rxMeta_r, rxSync_r, rxPrev_r, busy_r;
    logic [CW-1:0] cnt_r;
    logic [3:0] bitIdx_r;
    logic [7:0] shift_r;

    // two-stage synchroniser, then edge history
    // cleared low: a pin held low from reset must never look like a falling edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rxMeta_r <= 1'b0;
            rxSync_r <= 1'b0;
            rxPrev_r <= 1'b0;
        end else begin
            rxMeta_r <= rxPin;
            rxSync_r <= rxMeta_r;
            rxPrev_r <= rxSync_r;
        end
    end

    // frame only starts on a falling edge, so a line stuck low yields nothing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
            bitIdx_r <= 4'h0;
            shift_r <= 8'h00;
            rxValid <= 1'b0;
            rxData <= 8'h00;
            rxBreak <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (!busy_r) begin
                if (rxPrev_r && !rxSync_r) begin
                    busy_r <= 1'b1;
                    cnt_r <= CW'(BIT_CYCLES / 2);
                    bitIdx_r <= 4'h0;
                end
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end else begin
                cnt_r <= CW'(BIT_CYCLES - 1);
                bitIdx_r <= bitIdx_r + 4'h1;
                if (bitIdx_r == 4'h0 && rxSync_r) begin
                    busy_r <= 1'b0; // glitch, not a start bit
                end else if (bitIdx_r == 4'h9) begin
                    busy_r <= 1'b0;
                    rxValid <= 1'b1;
                    rxData <= shift_r;
                    rxBreak <= !rxSync_r && shift_r == 8'h00;
                end else if (bitIdx_r != 4'h0) begin
                    shift_r <= {rxSync_r, shift_r[7:1]};
                end
            end
        end
    end

    stuckLow_a: assert property (@(posedge clock) disable iff (!resetn)
        !busy_r && !rxPrev_r && !rxSync_r |=> !busy_r) else $error("receiver started without a falling edge");
endmodule : serial_rx

// ===== rtl/serial_tx.sv
// async serial transmitter, 8n1 frames or a ten-bit break
// assumes send and sendBreak are single pulses given while not busy
`timescale 1ns/1ns
module serial_tx #(
    parameter int BIT_CYCLES = 16001
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // request
    input wire logic send,
    input wire logic sendBreak,
    input wire logic [7:0] data,
    // line
    output logic line,
    output logic busy
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    logic [CW-1:0] cnt_r;
    logic [9:0] shift_r;
    logic [3:0] left_r;

    assign busy = left_r != 4'h0;

    // shift out lsb first; a break is simply an all-zero frame
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            shift_r <= 10'h3ff;
            left_r <= 4'h0;
            line <= 1'b1;
        end else if (!busy && (send || sendBreak)) begin
            shift_r <= sendBreak ? 10'h000 : {1'b1, data, 1'b0};
            left_r <= 4'ha;
            cnt_r <= CW'(BIT_CYCLES - 1);
            line <= 1'b1;
        end else if (busy) begin
            line <= shift_r[0];
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end else begin
                cnt_r <= CW'(BIT_CYCLES - 1);
                shift_r <= {1'b1, shift_r[9:1]};
                left_r <= left_r - 4'h1;
                if (left_r == 4'h1) begin
                    line <= 1'b1;
                end
            end
        end
    end

    breakLow_a: assert property (@(posedge clock) disable iff (!resetn)
        !busy && sendBreak |=> ##1 !line [*8]) else $error("break not held low");
endmodule : serial_tx

// ===== testbench/host_model.sv
// host side of the serial link: 8n1 frames or a break toward the device, pull-up on its tx line
// assumes the bench clock and a bit time of BIT_CYCLES clock cycles
`timescale 1ns/1ns
module host_model #(
    parameter int BIT_CYCLES = 16
) (
    // clock
    input wire logic clock,
    // device pins
    input wire logic txPinOut,
    input wire logic txPinOeN,
    output logic rxPin,
    // requests from the bench
    input wire logic sendReq,
    input wire logic sendBrk,
    input wire logic [7:0] sendData,
    input wire logic loopBack,
    input wire logic holdLow,
    output logic sendBusy
);
    logic [9:0] frame;
    int cnt;
    logic txLine;
    logic hostLine;
    initial sendBusy = 1'b0;
    // released open-drain line floats up to our pull-up
    assign txLine = txPinOeN ? 1'b1 : txPinOut;
    // one frame per request, start bit first, lsb first
    always @(posedge clock) begin
        if (sendBusy) begin
            cnt <= cnt + 1;
            if (cnt == 10 * BIT_CYCLES - 1) sendBusy <= 1'b0;
        end else if (sendReq) begin
            frame <= sendBrk ? 10'h000 : {1'b1, sendData, 1'b0};
            cnt <= 0;
            sendBusy <= 1'b1;
        end
    end
    assign hostLine = sendBusy ? frame[cnt / BIT_CYCLES] : 1'b1;
    // idle high; loop back feeds the break home, hold low never makes an edge
    assign rxPin = holdLow ? 1'b0 : (loopBack ? txLine : hostLine);
endmodule : host_model

// ===== testbench/test_serial_bootstrap_loader.sv
// self-checking bench of the bootstrap loader: first-character decisions, download, registers
// assumes one ahb-lite master here and the host model on the serial pins
`timescale 1ns/1ns
`include "boot_loader_map.svh"
module test_serial_bootstrap_loader;
    localparam int BC = 16;
    localparam int CHAR = 10 * BC;
    typedef struct {logic [7:0] first; logic brk; logic loop; int n; logic [15:0] jump;} row_t;
    row_t rows [6] = '{'{8'h55, 0, 0, 0, 16'h0000}, '{8'h00, 0, 0, 0, 16'hb600}, '{8'h00, 1, 0, 0, 16'hb600},
        '{8'h00, 0, 1, 0, 16'hb600}, '{8'hff, 0, 0, 0, 16'h0000}, '{8'hff, 0, 0, 3, 16'h0000}};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, sendReq = 1'b0, sendBrk = 1'b0, loopBack = 1'b0, holdLow = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] sendData = 8'h00;
    logic hreadyout, hresp, rxPin, txPinOut, txPinOeN, programStart, sendBusy;
    logic [15:0] jumpAddr, stackPtr;
    logic serialRxEnable, serialTxEnable, serialPinOwn, wireOrMode, bootRomMapEnable;
    logic resetDisable, expandedMode, privilegedAccess, protectSuspend;
    int err_count = 0, checked = 0, cycles = 0, relCyc = 0;
    serial_bootstrap_loader #(.BIT_CYCLES(BC), .RAM_DEPTH(512)) i_serial_bootstrap_loader (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOeN(txPinOeN), .programStart(programStart),
        .jumpAddr(jumpAddr), .stackPtr(stackPtr), .serialRxEnable(serialRxEnable), .serialTxEnable(serialTxEnable),
        .serialPinOwn(serialPinOwn), .wireOrMode(wireOrMode), .bootRomMapEnable(bootRomMapEnable),
        .resetDisable(resetDisable), .expandedMode(expandedMode), .privilegedAccess(privilegedAccess),
        .protectSuspend(protectSuspend));
    host_model #(.BIT_CYCLES(BC)) i_host_model (.clock(clock), .txPinOut(txPinOut), .txPinOeN(txPinOeN),
        .rxPin(rxPin), .sendReq(sendReq), .sendBrk(sendBrk), .sendData(sendData), .loopBack(loopBack),
        .holdLow(holdLow), .sendBusy(sendBusy));
    always #4 clock = ~clock;
    // hang guard, well above the longest run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // single transfer: address phase held until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic doReset;
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        check({programStart, txPinOeN, txPinOut, stackPtr}, 19'h20000, "reset outputs");
        resetn <= 1'b1;
        relCyc = cycles;
    endtask : doReset
    task automatic sendChar(input logic [7:0] b, input logic brk);
        @(posedge clock);
        while (sendBusy === 1'b1) @(posedge clock);
        sendReq <= 1'b1;
        sendData <= b;
        sendBrk <= brk;
        @(posedge clock);
        sendReq <= 1'b0;
    endtask : sendChar
    task automatic waitStart;
        while (programStart !== 1'b1) @(posedge clock);
    endtask : waitStart
    initial begin
        repeat (2) @(posedge clock);
        // ordinary first-character cases, one row each
        for (int k = 0; k < 6; k++) begin
            loopBack <= rows[k].loop;
            doReset();
            repeat (6 * CHAR) @(posedge clock);
            if (!rows[k].loop) check(programStart, 1'b0, "start before rate char");
            if (!rows[k].loop) sendChar(rows[k].first, rows[k].brk);
            for (int i = 0; i < rows[k].n; i++) sendChar(8'h11 + i[7:0], 1'b0);
            waitStart();
            check(cycles - relCyc >= 2 * CHAR, 1'b1, "start delay");
            check(jumpAddr, rows[k].jump, "jump address");
            check(stackPtr, 16'h01ff, "stack");
            check({serialRxEnable, serialTxEnable, serialPinOwn, wireOrMode}, 4'hf, "serial setup");
            ahb(1'b0, `REG_TIMER, 32'h0);
            check(rd >= 2 * CHAR, 1'b1, "timer advanced");
            ahb(1'b0, `REG_COUNT, 32'h0);
            check(rd, rows[k].n, "bytes loaded");
            ahb(1'b0, 32'h800 + 4 * (rows[k].n - 1), 32'h0);
            if (rows[k].n > 0) check(rd, 8'h10 + rows[k].n, "ram byte");
            $display("test row %0d done", k);
        end
        loopBack <= 1'b0;
        // special-mode control bits, software changes, unmapped and read-only places
        doReset();
        ahb(1'b0, `REG_CTRL, 32'h0);
        check(rd, 32'h73, "ctrl after start");
        check({bootRomMapEnable, resetDisable, privilegedAccess, protectSuspend, expandedMode},
            5'h1e, "mode");
        ahb(1'b1, `REG_CTRL, 32'h76);
        ahb(1'b0, `REG_CTRL, 32'h0);
        check(rd, 32'h76, "ctrl write");
        check({bootRomMapEnable, expandedMode, hresp, hreadyout}, 4'h5, "rom off, expanded");
        ahb(1'b1, 32'h20, 32'h5a);
        ahb(1'b0, 32'h20, 32'h0);
        check(rd, 32'h0, "unmapped");
        ahb(1'b1, `REG_STACK, 32'hffff);
        ahb(1'b0, `REG_STACK, 32'h0);
        check(rd, 32'h0, "read-only stack");
        $display("test registers done");
        // a line held low gives no character; a later real edge does
        holdLow <= 1'b1;
        doReset();
        repeat (8 * CHAR) @(posedge clock);
        ahb(1'b0, `REG_STATUS, 32'h0);
        check({programStart, rd[2:0]}, 4'h1, "held low");
        holdLow <= 1'b0;
        repeat (CHAR) @(posedge clock);
        sendChar(8'h55, 1'b0);
        waitStart();
        check(jumpAddr, 16'h0000, "jump after edge");
        $display("test held low done");
        // fixed length: idle after 255 bytes does not end it, byte 256 does
        doReset();
        ahb(1'b1, `REG_CTRL, 32'h7b);
        sendChar(8'hff, 1'b0);
        for (int i = 0; i < 256; i++) begin
            if (i == 255) repeat (6 * CHAR) @(posedge clock);
            if (i == 255) check(programStart, 1'b0, "fixed early end");
            sendChar(i[7:0] ^ 8'h5a, 1'b0);
        end
        waitStart();
        ahb(1'b0, `REG_COUNT, 32'h0);
        check(rd, 32'd256, "fixed count");
        ahb(1'b0, 32'h800 + 4 * 255, 32'h0);
        check(rd, 32'ha5, "last ram byte");
        check(jumpAddr, 16'h0000, "fixed jump");
        $display("test fixed length done");
        end_sim();
    end
endmodule : test_serial_bootstrap_loader
